/* File: hw/saf_top.sv */
// serial codec port fifos, request logic and master link engine
// assumes an ahb-lite master on hclk and a codec sampling on rising clock
`timescale 1ns/1ns
`include "saf_cfg.svh"
module saf_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   output var  logic        serial_clock_pin,
   output var  logic        frame_sync_pin,
   output var  logic        serial_out_pin,
   input  wire logic        serial_in_pin,
   input  wire logic        dma_tx_ack,
   input  wire logic        dma_rx_ack,
   output var  logic        tx_flag,
   output var  logic        rx_flag
);

////////////////////////////////////////////////////////////////////
// bus decode
saf_pkg::saf_req_type req_d;
saf_pkg::saf_req_type req_q;
wire addr_ok = hsel && htrans[1] && hready;
wire rd_ev   = addr_ok && !hwrite;
wire wr_ev   = req_q.act && req_q.wr;
wire wr_ctrl = wr_ev && req_q.addr == `SAF_OFS_CTRL;
wire wr_fctl = wr_ev && req_q.addr == `SAF_OFS_FCTL;
wire wr_stat = wr_ev && req_q.addr == `SAF_OFS_STAT;
wire wr_txd  = wr_ev && req_q.addr == `SAF_OFS_TXD;
wire wr_sclk = wr_ev && req_q.addr == `SAF_OFS_SCLK;
wire rx_rd   = rd_ev && haddr[7:0] == `SAF_OFS_RXD;
assign req_d = '{addr: haddr[7:0], wr: hwrite, act: addr_ok};

////////////////////////////////////////////////////////////////////
// control registers
logic [3:0] ctrl_q;
logic [2:0] txthr_q;
logic [2:0] rxthr_q;
logic [7:0] div_q;
logic [3:0] err_q;
logic [3:0] err_set;
wire sce = ctrl_q[`SAF_CTRL_SCE];
wire fs_en = ctrl_q[`SAF_CTRL_FS];
wire tx_en = ctrl_q[`SAF_CTRL_TX];
wire rx_en = ctrl_q[`SAF_CTRL_RX];
wire [3:0] err_clr = wr_stat ? hwdata[`SAF_ERR_LSB +: 4] : 4'h0;
wire [3:0] err_d = (err_q & ~err_clr) | err_set;

always_ff @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      req_q   <= '0;
      ctrl_q  <= `SAF_CTRL_RST;
      txthr_q <= `SAF_THR_RST;
      rxthr_q <= `SAF_THR_RST;
      div_q   <= `SAF_DIV_RST;
      err_q   <= 4'h0;
   end else begin
      req_q <= req_d;
      err_q <= err_d;
      if (wr_ctrl) begin
         ctrl_q <= hwdata[3:0];
      end
      if (wr_fctl) begin
         txthr_q <= hwdata[`SAF_TXTHR_LSB +: 3];
         rxthr_q <= hwdata[`SAF_RXTHR_LSB +: 3];
      end
      if (wr_sclk) begin
         div_q <= hwdata[7:0];
      end
   end
end

////////////////////////////////////////////////////////////////////
// transmit fifo
saf_pkg::saf_word_type tx_mem [16];
logic [3:0] tx_wp_q;
logic [3:0] tx_rp_q;
logic [4:0] tx_cnt_q;
logic       tx_pop;
wire tx_full  = tx_cnt_q == `SAF_DEPTH;
wire tx_push  = wr_txd && !tx_full;
wire tx_ovr   = wr_txd && tx_full;
wire [4:0] tx_cnt_d = tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
wire [4:0] tx_free = `SAF_DEPTH - tx_cnt_q;

always_ff @(posedge hclk) begin
   if (tx_push) begin
      tx_mem[tx_wp_q] <= hwdata;
   end
end

always_ff @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      tx_wp_q  <= 4'h0;
      tx_rp_q  <= 4'h0;
      tx_cnt_q <= 5'h00;
   end else begin
      tx_wp_q  <= tx_wp_q + {3'h0, tx_push};
      tx_rp_q  <= tx_rp_q + {3'h0, tx_pop};
      tx_cnt_q <= tx_cnt_d;
   end
end

////////////////////////////////////////////////////////////////////
// receive fifo
saf_pkg::saf_word_type rx_mem [16];
saf_pkg::saf_word_type rx_last_q;
logic [3:0] rx_wp_q;
logic [3:0] rx_rp_q;
logic [4:0] rx_cnt_q;
logic       rx_ev;
logic [31:0] rx_word;
wire rx_full = rx_cnt_q == `SAF_DEPTH;
wire rx_push = rx_ev && !rx_full;
wire rx_ovr  = rx_ev && rx_full;
wire rx_pop  = rx_rd && rx_cnt_q != 5'h00;
wire rx_udr  = rx_rd && rx_cnt_q == 5'h00;
wire [31:0] rx_out = rx_pop ? rx_mem[rx_rp_q] : rx_last_q;
wire [4:0] rx_cnt_d = rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};

always_ff @(posedge hclk) begin
   if (rx_push) begin
      rx_mem[rx_wp_q] <= rx_word;
   end
end

always_ff @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      rx_wp_q   <= 4'h0;
      rx_rp_q   <= 4'h0;
      rx_cnt_q  <= 5'h00;
      rx_last_q <= 32'h0000_0000;
   end else begin
      rx_wp_q   <= rx_wp_q + {3'h0, rx_push};
      rx_rp_q   <= rx_rp_q + {3'h0, rx_pop};
      rx_cnt_q  <= rx_cnt_d;
      rx_last_q <= rx_out;
   end
end

////////////////////////////////////////////////////////////////////
// link engine
logic [7:0]  dcnt_q;
logic        sck_q;
logic [4:0]  bit_q;
logic        run_q;
logic [31:0] tsh_q;
logic [31:0] last_q;
logic [31:0] rsh_q;
logic        fs_q;
logic        sdo_q;
logic        sin1_q;
logic        sin2_q;
wire hit   = sce && dcnt_q == div_q;
wire fall  = hit && sck_q;
wire rise  = hit && !sck_q;
wire edge0 = bit_q == 5'h00;
wire start = fall && edge0 && fs_en;
assign tx_pop = start && tx_en && tx_cnt_q != 5'h00;
wire tx_udr = start && tx_en && tx_cnt_q == 5'h00;
wire [31:0] load_w = !tx_en ? 32'h0000_0000 : tx_pop ? tx_mem[tx_rp_q] : last_q;
wire [31:0] tsh_d = start ? load_w : {tsh_q[30:0], 1'b0};
wire adv = fall && (!edge0 || fs_en);
assign rx_ev   = rise && edge0 && run_q && rx_en;
assign rx_word = {rsh_q[30:0], sin2_q};
assign err_set = {rx_udr, rx_ovr, tx_ovr, tx_udr};

always_ff @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      sin1_q <= 1'b0;
      sin2_q <= 1'b0;
   end else begin
      sin1_q <= serial_in_pin;
      sin2_q <= sin1_q;
   end
end

always_ff @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      dcnt_q <= 8'h00;
      sck_q  <= 1'b0;
      bit_q  <= 5'h00;
      run_q  <= 1'b0;
      fs_q   <= 1'b0;
   end else if (!sce) begin
      dcnt_q <= 8'h00;
      sck_q  <= 1'b0;
      bit_q  <= 5'h00;
      run_q  <= 1'b0;
      fs_q   <= 1'b0;
   end else begin
      dcnt_q <= hit ? 8'h00 : dcnt_q + 8'h01;
      sck_q  <= sck_q ^ hit;
      bit_q  <= bit_q + {4'h0, adv};
      if (fall && edge0) begin
         run_q <= fs_en;
      end
      if (fall) begin
         fs_q <= start;
      end
   end
end

always_ff @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      tsh_q  <= 32'h0000_0000;
      last_q <= 32'h0000_0000;
      rsh_q  <= 32'h0000_0000;
      sdo_q  <= 1'b0;
   end else begin
      if (fall) begin
         tsh_q <= tsh_d;
         sdo_q <= tsh_d[31];
      end
      if (tx_pop) begin
         last_q <= load_w;
      end
      if (rise) begin
         rsh_q <= rx_word;
      end
   end
end

////////////////////////////////////////////////////////////////////
// requests and flags
logic tx_req_q;
logic rx_req_q;
logic tx_flag_q;
logic rx_flag_q;
wire [4:0] tx_need = txthr_q == `SAF_THR_4  ? `SAF_LVL_12 :
                     txthr_q == `SAF_THR_8  ? `SAF_LVL_8  :
                     txthr_q == `SAF_THR_12 ? `SAF_LVL_4  :
                     txthr_q == `SAF_THR_ALL ? `SAF_LVL_1 : `SAF_DEPTH;
wire [4:0] rx_need = rxthr_q == `SAF_THR_4  ? `SAF_LVL_4  :
                     rxthr_q == `SAF_THR_8  ? `SAF_LVL_8  :
                     rxthr_q == `SAF_THR_12 ? `SAF_LVL_12 :
                     rxthr_q == `SAF_THR_ALL ? `SAF_DEPTH : `SAF_LVL_1;
wire tx_req_d = tx_en && tx_free >= tx_need;
wire rx_req_d = rx_en && rx_cnt_q >= rx_need;
wire tx_flag_d = tx_req_d && !dma_tx_ack && (tx_flag_q || !tx_req_q);
wire rx_flag_d = rx_req_d && !dma_rx_ack && (rx_flag_q || !rx_req_q);

always_ff @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      tx_req_q  <= 1'b0;
      rx_req_q  <= 1'b0;
      tx_flag_q <= 1'b0;
      rx_flag_q <= 1'b0;
   end else begin
      tx_req_q  <= tx_req_d;
      rx_req_q  <= rx_req_d;
      tx_flag_q <= tx_flag_d;
      rx_flag_q <= rx_flag_d;
   end
end

////////////////////////////////////////////////////////////////////
// read data and outputs
wire [31:0] fctl = {3'h0, rx_cnt_q, 5'h00, rxthr_q, 3'h0, tx_free, 5'h00, txthr_q};
wire [31:0] stat = {26'h0, err_q, rx_req_q, tx_req_q};
wire [7:0] ra = haddr[7:0];
wire [31:0] rd_data = ra == `SAF_OFS_CTRL ? {28'h0, ctrl_q} :
                      ra == `SAF_OFS_FCTL ? fctl :
                      ra == `SAF_OFS_STAT ? stat :
                      ra == `SAF_OFS_RXD  ? rx_out :
                      ra == `SAF_OFS_SCLK ? {24'h0, div_q} : 32'h0000_0000;

always_ff @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
   end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_ev) begin
         hrdata <= rd_data;
      end
   end
end

assign serial_clock_pin = sck_q;
assign frame_sync_pin   = fs_q;
assign serial_out_pin   = sdo_q;
assign tx_flag          = tx_flag_q;
assign rx_flag          = rx_flag_q;

////////////////////////////////////////////////////////////////////
// checks
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);

bus_two_cycle_a: assert property (addr_ok |=> hreadyout && !hresp)
   else $error("fifo access not done in two cycles");
tx_depth_a: assert property (tx_cnt_q <= `SAF_DEPTH && rx_cnt_q <= `SAF_DEPTH)
   else $error("fifo count beyond depth");
rx_pop_one_a: assert property ((rx_pop && !rx_push) |=> rx_cnt_q == $past(rx_cnt_q) - 5'h01)
   else $error("receive read did not drain one entry");
tx_ovr_keep_a: assert property ((tx_ovr && !tx_pop) |=> tx_full && err_q[1])
   else $error("full transmit write not ignored");
tx_req_off_a: assert property (!tx_en |=> !tx_req_q && !tx_flag_q)
   else $error("transmit request without enable");
rx_thr_full_a: assert property ((rx_en && rxthr_q == `SAF_THR_ALL && rx_full) |=> rx_req_q)
   else $error("receive request missing at full");
udr_repeat_a: assert property (tx_udr |=> tsh_q == $past(last_q) && err_q[0])
   else $error("underrun did not repeat last word");
sck_run_a: assert property (hit |=> sck_q != $past(sck_q))
   else $error("serial clock stalled");
fs_start_a: assert property (start |=> fs_q ##1 fs_q)
   else $error("frame sync not driven at frame start");
dma_ack_a: assert property (dma_tx_ack |=> !tx_flag_q)
   else $error("dma acknowledge did not clear flag");

endmodule : saf_top

/* File: inc/saf_cfg.svh */
// register map, field positions, reset values and levels of the fifo block
// assumes inclusion by bare name from inc/
`ifndef SAF_CFG_SVH
`define SAF_CFG_SVH
`define SAF_OFS_CTRL   8'h00
`define SAF_OFS_FCTL   8'h04
`define SAF_OFS_STAT   8'h08
`define SAF_OFS_TXD    8'h0C
`define SAF_OFS_RXD    8'h10
`define SAF_OFS_SCLK   8'h14
`define SAF_CTRL_SCE   0
`define SAF_CTRL_FS    1
`define SAF_CTRL_TX    2
`define SAF_CTRL_RX    3
`define SAF_TXTHR_LSB  0
`define SAF_RXTHR_LSB  16
`define SAF_ERR_LSB    2
`define SAF_CTRL_RST   4'h0
`define SAF_THR_RST    3'h0
`define SAF_DIV_RST    8'h13
`define SAF_DEPTH      5'h10
`define SAF_LVL_1      5'h01
`define SAF_LVL_4      5'h04
`define SAF_LVL_8      5'h08
`define SAF_LVL_12     5'h0C
`define SAF_THR_4      3'h4
`define SAF_THR_8      3'h5
`define SAF_THR_12     3'h6
`define SAF_THR_ALL    3'h7
`endif

/* File: inc/saf_pkg.sv */
// types shared by the fifo block
// assumes nothing of its surroundings
package saf_pkg;
   typedef logic [31:0] saf_word_type;
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       act;
   } saf_req_type;
endpackage : saf_pkg

/* File: tb/saf_codec_model.sv */
// codec model on the far side of the serial link
// assumes link pins of saf_top, msb first, sync with first bit
`timescale 1ns/1ns
module saf_codec_model (
   input  wire logic sclk,
   input  wire logic fsync,
   input  wire logic sdo,
   output var  logic sdi
);
   logic [31:0] tx_sh;
   logic [31:0] rx_sh;
   logic [31:0] got_q[$];
   int          tx_b = 32;
   int          rx_n = 0;
   int          k = 0;
   initial sdi = 1'h0;
   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge sclk) begin
      #1; // sync settles in the edge's time step
      if (fsync) begin
         tx_sh = {16'hE71D, k[15:0]};
         k = k + 1;
         tx_b = 0;
      end
      sdi = (tx_b < 32) ? tx_sh[31 - tx_b] : ~sdi;
      tx_b = tx_b + 1;
   end
   always @(posedge sclk) begin
      rx_sh = fsync ? {31'h0, sdo} : {rx_sh[30:0], sdo};
      rx_n = fsync ? 1 : rx_n + 1;
      if (rx_n == 32) begin
         got_q.push_back(rx_sh);
      end
   end
endmodule : saf_codec_model

/* File: tb/saf_top_bench.sv */
// self-checking bench of the fifo block
// assumes saf_top, its register map header and the codec model
`timescale 1ns/1ns
`include "saf_cfg.svh"
module saf_top_bench;
   logic        hclk = 1'h0;
   logic        hresetn = 1'h0;
   logic        hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic        dma_tx_ack = 1'h0;
   logic        dma_rx_ack = 1'h0;
   logic        hreadyout;
   logic        hresp;
   logic        sclk;
   logic        fsync;
   logic        sdo;
   logic        sdi;
   logic        tx_flag;
   logic        rx_flag;
   logic [31:0] hrdata;
   logic [31:0] rd;
   int          fail_count = 0;
   int          check_count = 0;
   int          free_n;
   int          need;
   int          n;
   int          m;
   always #2 hclk = ~hclk;
   saf_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .serial_clock_pin(sclk), .frame_sync_pin(fsync), .serial_out_pin(sdo),
      .serial_in_pin(sdi), .dma_tx_ack(dma_tx_ack), .dma_rx_ack(dma_rx_ack),
      .tx_flag(tx_flag), .rx_flag(rx_flag));
   saf_codec_model codec_u (.sclk(sclk), .fsync(fsync), .sdo(sdo), .sdi(sdi));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] word(input int i);
      return {8'hC3, i[7:0], 16'h5AA5};
   endfunction : word
   function automatic logic [31:0] fctl(input logic [2:0] c, input int fr, input int v);
      return {3'h0, v[4:0], 8'h7, 8'(fr[4:0]), 5'h0, c};
   endfunction : fctl
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wait_ready();
      int t;
      t = 0;
      @(posedge hclk);
      while (hreadyout !== 1'h1 && t < 99) begin
         @(posedge hclk);
         t++;
      end
      if (t >= 99) begin
         fail_count++;
      end
   endtask : wait_ready
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      check("resp", 32'h0, {31'h0, hresp});
   endtask : bus
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      bus(a, 1'h0, 32'h0);
      check(what, exp, rd);
   endtask : rd_chk
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge hclk);
      fail_count++;
      print_verdict();
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      rd_chk(`SAF_OFS_FCTL, 32'h00001000, "fifo_ctl");
      rd_chk(`SAF_OFS_STAT, 32'h0, "status");
      rd_chk(8'h40, 32'h0, "unmapped");
      check("flags", 32'h0, {30'h0, tx_flag, rx_flag});
      bus(`SAF_OFS_CTRL, 1'h1, 32'h1);
      n = 0;
      m = 0;
      repeat (100) begin
         @(posedge hclk);
         n += sclk;
         m += fsync;
      end
      check("clock_runs", 32'h1, 32'(n > 20 && n < 80));
      check("no_sync", 32'h0, m);
      bus(`SAF_OFS_CTRL, 1'h1, 32'h5);
      free_n = 16;
      for (int j = 0; j < 5; j++) begin
         need = (j == 4) ? 1 : 16 - 4 * j;
         bus(`SAF_OFS_FCTL, 1'h1, fctl(j ? 3'(j + 3) : 3'h0, 0, 0));
         while (free_n > need) begin
            bus(`SAF_OFS_TXD, 1'h1, word(16 - free_n));
            free_n--;
         end
         rd_chk(`SAF_OFS_STAT, 32'h1, "tx_request");
         check("tx_flag", 32'h1, {31'h0, tx_flag});
         bus(`SAF_OFS_TXD, 1'h1, word(16 - free_n));
         free_n--;
         rd_chk(`SAF_OFS_FCTL, fctl(j ? 3'(j + 3) : 3'h0, free_n, 0), "tx_free");
         rd_chk(`SAF_OFS_STAT, 32'h0, "tx_request");
         check("tx_flag", 32'h0, {31'h0, tx_flag});
      end
      bus(`SAF_OFS_TXD, 1'h1, 32'hDEAD0000);
      rd_chk(`SAF_OFS_FCTL, fctl(3'h7, 0, 0), "full_ctl");
      rd_chk(`SAF_OFS_STAT, 32'h8, "overrun");
      bus(`SAF_OFS_CTRL, 1'h1, 32'hF);
      n = 0;
      while (codec_u.got_q.size() < 18 && n < 40000) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 40000) begin
         fail_count++;
      end
      repeat (100) @(posedge hclk);
      for (int i = 0; i < 16; i++) begin
         check("tx_word", word(i), codec_u.got_q[i]);
      end
      check("underrun_word", word(15), codec_u.got_q[16]);
      check("rx_flag", 32'h1, {31'h0, rx_flag});
      check("tx_flag_busy", 32'h1, {31'h0, tx_flag});
      dma_rx_ack <= 1'h1;
      dma_tx_ack <= 1'h1;
      @(posedge hclk);
      dma_rx_ack <= 1'h0;
      dma_tx_ack <= 1'h0;
      repeat (2) @(posedge hclk);
      check("rx_flag_ack", 32'h0, {31'h0, rx_flag});
      check("tx_flag_ack", 32'h0, {31'h0, tx_flag});
      rd_chk(`SAF_OFS_STAT, 32'h1F, "status_full");
      rd_chk(`SAF_OFS_FCTL, fctl(3'h7, 16, 16), "rx_valid");
      bus(`SAF_OFS_CTRL, 1'h1, 32'h3);
      for (int i = 0; i < 16; i++) begin
         rd_chk(`SAF_OFS_RXD, {16'hE71D, 16'(i)}, "rx_word");
         if (i == 0) begin
            rd_chk(`SAF_OFS_STAT, 32'h1C, "rx_request");
         end
      end
      rd_chk(`SAF_OFS_RXD, {16'hE71D, 16'hF}, "rx_empty");
      rd_chk(`SAF_OFS_STAT, 32'h3C, "underflow");
      bus(`SAF_OFS_STAT, 1'h1, 32'h3C);
      rd_chk(`SAF_OFS_STAT, 32'h0, "cleared");
      print_verdict();
   end
endmodule : saf_top_bench
